// >>> rtl/fast_read_pkg.sv
`default_nettype none
package fast_read_pkg;

	// ---------------------------------------------------------------
	// Opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO  = 8'heb;

	// ---------------------------------------------------------------
	// Field widths and lane codes
	// ---------------------------------------------------------------
	localparam int         ADDR_W    = 24;
	localparam int         BYTE_W    = 8;
	localparam int         CNT_W     = 5;
	localparam logic [2:0] LANES_1   = 3'h1;
	localparam logic [2:0] LANES_2   = 3'h2;
	localparam logic [2:0] LANES_4   = 3'h4;
	localparam logic [3:0] OE_DUAL   = 4'h3;
	localparam logic [3:0] OE_QUAD   = 4'hf;
	localparam logic [3:0] OE_NONE   = 4'h0;

	// ---------------------------------------------------------------
	// Phase lengths in link clocks
	// ---------------------------------------------------------------
	localparam int DUAL_OUT_DUMMY    = 8;
	localparam int DUAL_IO_DUMMY_DEF = 4;
	localparam int QUAD_MODE_CLKS    = 2;
	localparam int QUAD_DUMMY        = 4;

	// ---------------------------------------------------------------
	// Frame sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OPC,
		ST_ADDR,
		ST_MODE,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} state_t;

endpackage
`default_nettype wire

// >>> rtl/multi_io_fast_read_engine.sv
// Overview of operation
// - Dual-output read: opcode and 24-bit address serial, data two bits per clock.
// - Dual-output read: eight dummy clocks follow address before any data drive.
// - Input values during dual-output dummy clocks are ignored.
// - Dual I/O read takes the 24 address bits two per clock.
// - After dual I/O opcode, address, dummy and data are all two bits wide.
// - Dual I/O: address sampled on rising edges, data shifted on falling edges.
// - Address increments after every byte and wraps to zero past the top.
// - Quad I/O read: four bits per clock, two mode and four dummy clocks before data.
// - Quad I/O: address nibbles on rising edges, data nibbles on falling edges.
// - After quad I/O opcode, address, dummy and data are all four bits wide.
// - Quad data: io3 carries each nibble's top bit, io0 the lowest.
// - Chip select high during data stops the drive and ends the read.
// - Enhanced quad read: mode byte after address, then four dummy clocks.
// - Continuous mode kept only when mode upper nibble inverts lower nibble.
// - In continuous mode the next frame starts with the quad address directly.
// - Non-inverted mode byte cancels continuous mode from the next frame on.
// - A framed all-ones byte forces continuous mode off.
// - Quad I/O read during a write cycle is rejected, cycle untouched.
// - Opcode, address, dummy sampled on rising edges; data out on falling edges.
// - Dual-output read during a write cycle is rejected likewise.
`default_nettype none
module multi_io_fast_read_engine #(
	parameter int DUAL_IO_DUMMY = fast_read_pkg::DUAL_IO_DUMMY_DEF
)(
	// System clock side
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	input  wire logic                              write_busy,
	input  wire logic                              quad_command_mode,
	output logic                                   cont_active,
	output logic                                   reject_pulse,
	// Serial link
	input  wire logic                              sck,
	input  wire logic                              cs_n,
	input  wire logic [3:0]                        io_i,
	output logic      [3:0]                        io_o,
	output logic      [3:0]                        io_oe,
	// Array read port, link clock
	output logic      [fast_read_pkg::ADDR_W-1:0]  mem_addr,
	input  wire logic [fast_read_pkg::BYTE_W-1:0]  mem_data
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	fast_read_pkg::state_t                     state_r;
	logic [fast_read_pkg::CNT_W-1:0]           cnt_r;
	logic [fast_read_pkg::CNT_W-1:0]           phase_last;
	logic                                      last;
	logic [7:0]                                op_r;
	logic [7:0]                                op_nxt;
	logic [2:0]                                lanes_r;
	logic [fast_read_pkg::ADDR_W-1:0]          addr_r;
	logic [fast_read_pkg::ADDR_W-1:0]          addr_nxt;
	logic [3:0]                                mode_r;
	logic [7:0]                                mode_byte;
	logic                                      mode_keep;
	logic                                      cont_r;
	logic                                      rst_hold_r;
	logic                                      busy_s1_r;
	logic                                      busy_s2_r;
	logic                                      qcm_s1_r;
	logic                                      qcm_s2_r;
	logic                                      rej_tgl_r;
	logic                                      rej_s1_r;
	logic                                      rej_s2_r;
	logic                                      rej_s3_r;
	logic                                      cont_s1_r;
	logic                                      cont_s2_r;
	logic [3:0]                                grp_bits;
	logic [3:0]                                io_o_r;
	logic [3:0]                                io_oe_r;

	// ---------------------------------------------------------------
	// System domain: reset hold and crossings out of the link domain
	// ---------------------------------------------------------------
	// Registered reset, used as an asynchronous clear in the link domain
	// because the link clock may stand still while sys_rst is high
	always_ff @(posedge clk)
		rst_hold_r <= sys_rst;

	// Continuous-mode level and reject toggle brought into clk
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cont_s1_r <= 1'b0;
			cont_s2_r <= 1'b0;
			rej_s1_r  <= 1'b0;
			rej_s2_r  <= 1'b0;
			rej_s3_r  <= 1'b0;
		end
		else
		begin
			cont_s1_r <= cont_r;
			cont_s2_r <= cont_s1_r;
			rej_s1_r  <= rej_tgl_r;
			rej_s2_r  <= rej_s1_r;
			rej_s3_r  <= rej_s2_r;
		end
	end

	assign cont_active  = cont_s2_r;
	assign reject_pulse = rej_s2_r ^ rej_s3_r;

	// ---------------------------------------------------------------
	// Link domain: crossings in from the system side
	// ---------------------------------------------------------------
	// Busy and command-mode levels settle long before an opcode ends
	always_ff @(posedge sck or posedge rst_hold_r)
	begin
		if (rst_hold_r)
		begin
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
			qcm_s1_r  <= 1'b0;
			qcm_s2_r  <= 1'b0;
		end
		else
		begin
			busy_s1_r <= write_busy;
			busy_s2_r <= busy_s1_r;
			qcm_s1_r  <= quad_command_mode;
			qcm_s2_r  <= qcm_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Phase length decode
	// ---------------------------------------------------------------
	always_comb
	begin
		phase_last = '0;
		case (state_r)
			fast_read_pkg::ST_OPC:
				phase_last = qcm_s2_r ? 5'(fast_read_pkg::BYTE_W / 4 - 1)
				                      : 5'(fast_read_pkg::BYTE_W - 1);
			fast_read_pkg::ST_ADDR:
				case (lanes_r)
					fast_read_pkg::LANES_4: phase_last = 5'(fast_read_pkg::ADDR_W / 4 - 1);
					fast_read_pkg::LANES_2: phase_last = 5'(fast_read_pkg::ADDR_W / 2 - 1);
					default:                phase_last = 5'(fast_read_pkg::ADDR_W - 1);
				endcase
			fast_read_pkg::ST_MODE:
				phase_last = 5'(fast_read_pkg::QUAD_MODE_CLKS - 1);
			fast_read_pkg::ST_DUMMY:
				case (op_r)
					fast_read_pkg::OP_DUAL_OUT:
						phase_last = 5'(fast_read_pkg::DUAL_OUT_DUMMY - 1);
					fast_read_pkg::OP_DUAL_IO:
						phase_last = 5'(DUAL_IO_DUMMY - 1);
					default:
						phase_last = 5'(fast_read_pkg::QUAD_DUMMY - 1);
				endcase
			fast_read_pkg::ST_DATA:
				phase_last = (lanes_r == fast_read_pkg::LANES_4)
				           ? 5'(fast_read_pkg::BYTE_W / 4 - 1)
				           : 5'(fast_read_pkg::BYTE_W / 2 - 1);
			default:
				phase_last = '0;
		endcase
	end

	assign last = (cnt_r == phase_last);

	// Opcode shift: serial on io0, or a nibble in quad command mode
	assign op_nxt = qcm_s2_r ? {op_r[3:0], io_i} : {op_r[6:0], io_i[0]};

	// Address shift by the current lane width, msb first
	always_comb
	begin
		case (lanes_r)
			fast_read_pkg::LANES_4: addr_nxt = {addr_r[fast_read_pkg::ADDR_W-5:0], io_i};
			fast_read_pkg::LANES_2: addr_nxt = {addr_r[fast_read_pkg::ADDR_W-3:0], io_i[1:0]};
			default:                addr_nxt = {addr_r[fast_read_pkg::ADDR_W-2:0], io_i[0]};
		endcase
	end

	assign mode_byte = {mode_r, io_i};
	assign mode_keep = (mode_byte[7:4] == ~mode_byte[3:0]);

	// ---------------------------------------------------------------
	// Frame sequencer, rising edges; chip select high clears the frame
	// ---------------------------------------------------------------
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			state_r <= fast_read_pkg::ST_OPC;
			cnt_r   <= '0;
			op_r    <= '0;
			lanes_r <= fast_read_pkg::LANES_1;
			addr_r  <= '0;
			mode_r  <= '0;
		end
		else
		begin
			cnt_r <= last ? '0 : cnt_r + 5'h01;
			case (state_r)
				fast_read_pkg::ST_OPC:
					if (cont_r)
					begin
						// First edge of an opcode-less frame is address nibble one
						op_r    <= fast_read_pkg::OP_QUAD_IO;
						lanes_r <= fast_read_pkg::LANES_4;
						addr_r  <= {addr_r[fast_read_pkg::ADDR_W-5:0], io_i};
						cnt_r   <= 5'h01;
						state_r <= busy_s2_r ? fast_read_pkg::ST_IGNORE
						                     : fast_read_pkg::ST_ADDR;
					end
					else
					begin
						op_r <= op_nxt;
						if (last)
						begin
							case (op_nxt)
								fast_read_pkg::OP_DUAL_OUT:
									lanes_r <= fast_read_pkg::LANES_1;
								fast_read_pkg::OP_DUAL_IO:
									lanes_r <= fast_read_pkg::LANES_2;
								default:
									lanes_r <= fast_read_pkg::LANES_4;
							endcase
							if (busy_s2_r)
								state_r <= fast_read_pkg::ST_IGNORE;
							else if (op_nxt == fast_read_pkg::OP_DUAL_OUT
							      || op_nxt == fast_read_pkg::OP_DUAL_IO
							      || op_nxt == fast_read_pkg::OP_QUAD_IO)
								state_r <= fast_read_pkg::ST_ADDR;
							else
								state_r <= fast_read_pkg::ST_IGNORE;
						end
					end
				fast_read_pkg::ST_ADDR:
				begin
					addr_r <= addr_nxt;
					if (last)
						state_r <= (op_r == fast_read_pkg::OP_QUAD_IO)
						         ? fast_read_pkg::ST_MODE
						         : fast_read_pkg::ST_DUMMY;
				end
				fast_read_pkg::ST_MODE:
				begin
					mode_r <= io_i;
					if (last)
						state_r <= fast_read_pkg::ST_DUMMY;
				end
				fast_read_pkg::ST_DUMMY:
					// Input lines are not looked at here
					if (last)
					begin
						state_r <= fast_read_pkg::ST_DATA;
						if (op_r == fast_read_pkg::OP_DUAL_OUT)
							lanes_r <= fast_read_pkg::LANES_2;
					end
				fast_read_pkg::ST_DATA:
					// Natural overflow of the 24-bit counter is the wrap to zero
					if (last)
						addr_r <= addr_r + 24'h000001;
				fast_read_pkg::ST_IGNORE:
					cnt_r <= '0;
				default:
					state_r <= fast_read_pkg::ST_IGNORE;
			endcase
		end
	end

	assign mem_addr = addr_r;

	// ---------------------------------------------------------------
	// Continuous mode and reject event; these outlive the frame
	// ---------------------------------------------------------------
	// An all-ones escape byte shows io0 high on both mode edges, which can
	// never be an inverted pair, so it lands in the cancel branch too
	always_ff @(posedge sck or posedge rst_hold_r)
	begin
		if (rst_hold_r)
			cont_r <= 1'b0;
		else if (!cs_n && state_r == fast_read_pkg::ST_MODE && last)
			cont_r <= mode_keep;
	end

	always_ff @(posedge sck or posedge rst_hold_r)
	begin
		if (rst_hold_r)
			rej_tgl_r <= 1'b0;
		else if (!cs_n && state_r != fast_read_pkg::ST_IGNORE && busy_s2_r
		      && ((state_r == fast_read_pkg::ST_OPC && (cont_r || last))))
			rej_tgl_r <= ~rej_tgl_r;
	end

	// ---------------------------------------------------------------
	// Data drive, falling edges
	// ---------------------------------------------------------------
	// Group select: io3 (or io1) carries the top bit of each group
	always_comb
	begin
		case (lanes_r)
			fast_read_pkg::LANES_4:
				grp_bits = cnt_r[0] ? mem_data[3:0] : mem_data[7:4];
			default:
				case (cnt_r[1:0])
					2'h0:    grp_bits = {2'h0, mem_data[7:6]};
					2'h1:    grp_bits = {2'h0, mem_data[5:4]};
					2'h2:    grp_bits = {2'h0, mem_data[3:2]};
					default: grp_bits = {2'h0, mem_data[1:0]};
				endcase
		endcase
	end

	// Enable only in the data phase; the host must already have let io0 go
	always_ff @(negedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			io_o_r  <= '0;
			io_oe_r <= fast_read_pkg::OE_NONE;
		end
		else if (state_r == fast_read_pkg::ST_DATA)
		begin
			io_o_r  <= grp_bits;
			io_oe_r <= (lanes_r == fast_read_pkg::LANES_4)
			         ? fast_read_pkg::OE_QUAD : fast_read_pkg::OE_DUAL;
		end
		else
			io_oe_r <= fast_read_pkg::OE_NONE;
	end

	assign io_o  = io_o_r;
	assign io_oe = io_oe_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	dual_out_dummy_a: assert property (@(posedge sck) disable iff (cs_n)
		$rose(state_r == fast_read_pkg::ST_DATA) && op_r == fast_read_pkg::OP_DUAL_OUT
		|-> $past(state_r == fast_read_pkg::ST_DUMMY, 8))
		else $error("dual output data began without eight dummy clocks");

	quad_dummy_a: assert property (@(posedge sck) disable iff (cs_n)
		$rose(state_r == fast_read_pkg::ST_DATA) && op_r == fast_read_pkg::OP_QUAD_IO
		|-> $past(state_r == fast_read_pkg::ST_DUMMY, 4)
		 && $past(state_r == fast_read_pkg::ST_MODE, 5))
		else $error("quad data not preceded by mode and four dummies");

	no_early_drive_a: assert property (@(negedge sck) disable iff (cs_n)
		state_r != fast_read_pkg::ST_DATA |=> io_oe == fast_read_pkg::OE_NONE)
		else $error("lines driven outside the data phase");

	addr_wrap_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_DATA && last
		|=> addr_r == 24'($past(addr_r) + 24'h000001))
		else $error("address did not advance after a byte");

	mode_keep_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_MODE && last && mode_keep |=> cont_r)
		else $error("inverted mode byte did not keep continuous mode");

	mode_exit_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_MODE && last && !mode_keep |=> !cont_r)
		else $error("plain mode byte did not cancel continuous mode");

	busy_reject_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_OPC && !cont_r && last && busy_s2_r
		|=> state_r == fast_read_pkg::ST_IGNORE ##1 state_r == fast_read_pkg::ST_IGNORE)
		else $error("read accepted during a write cycle");

	lane_width_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_ADDR && op_r == fast_read_pkg::OP_DUAL_IO
		|-> lanes_r == fast_read_pkg::LANES_2)
		else $error("dual I/O address not two bits wide");

	cont_start_a: assert property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_OPC && cont_r && !busy_s2_r
		|=> state_r == fast_read_pkg::ST_ADDR && lanes_r == fast_read_pkg::LANES_4)
		else $error("continuous frame did not start with the address");

	quad_data_c: cover property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_DATA && op_r == fast_read_pkg::OP_QUAD_IO);

	cont_frame_c: cover property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_OPC && cont_r);

	reject_c: cover property (@(posedge sck) disable iff (cs_n)
		state_r == fast_read_pkg::ST_IGNORE && busy_s2_r);

endmodule
`default_nettype wire

// >>> sim/flash_host_model.sv
`default_nettype none
module flash_host_model (
	// Link pins
	output logic            sck,
	output logic            cs_n,
	output logic [3:0]      io_i,
	// Device drive
	input  wire logic [3:0] io_o,
	input  wire logic [3:0] io_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] host_d;
	logic [3:0] host_oe;
	logic [3:0] idle_r;

	// Released lines toggle so a stale level never passes for data
	always @(posedge sck)
		idle_r <= ~idle_r;

	// Wire level seen by the device
	always_comb
		for (int k = 0; k < 4; k++)
			io_i[k] = io_oe[k] ? io_o[k] : (host_oe[k] ? host_d[k] : idle_r[k]);

	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		host_d = 4'h0;
		host_oe = 4'h0;
		idle_r = 4'h5;
	end

	// One 48 ns link clock; clock stands still outside frames
	// Release waits a little past the rise so the device samples a settled line
	task automatic tick(input logic rel);
		#24 sck = 1'b1;
		#1;
		if (rel)
			host_oe = 4'h0; // Let go before the next fall
		#23 sck = 1'b0;
	endtask

	task automatic start();
		cs_n = 1'b0;
		#12;
	endtask

	// Msb-first groups of w bits
	task automatic shift(input int w, input int nb, input logic [23:0] v);
		logic [23:0] g;
		for (int i = 0; i < nb / w; i++)
		begin
			g = v >> (nb - w * (i + 1));
			host_oe = 4'((1 << w) - 1);
			host_d = g[3:0] & host_oe;
			tick(1'b0);
		end
	endtask

	// Dummy clocks carry noise
	task automatic dummy(input int n, input int w);
		for (int i = 0; i < n; i++)
		begin
			host_oe = 4'((1 << w) - 1);
			host_d = 4'($urandom);
			tick(i == n - 1);
		end
	endtask

	task automatic clocks(input int n);
		repeat (n) tick(1'b1);
	endtask

	// Deselect may land mid-byte
	task automatic stop();
		#12 cs_n = 1'b1;
		host_oe = 4'h0;
		#1;
	endtask
endmodule
`default_nettype wire

// >>> sim/multi_io_fast_read_engine_test.sv
`default_nettype none
module multi_io_fast_read_engine_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------
	// Signals and tallies
	// ----------------
	logic                             clk;
	logic                             sys_rst;
	logic                             write_busy;
	logic                             quad_command_mode;
	logic                             cont_active;
	logic                             reject_pulse;
	logic                             sck;
	logic                             cs_n;
	logic [3:0]                       io_i;
	logic [3:0]                       io_o;
	logic [3:0]                       io_oe;
	logic [fast_read_pkg::ADDR_W-1:0] mem_addr;
	logic [fast_read_pkg::BYTE_W-1:0] mem_data;
	int                               n_fail;
	int                               comparisons;
	int                               n_rej;
	int                               nbit;
	logic                             cont;
	logic [7:0]                       sh;
	logic [11:0]                      expq[$];
	logic [7:0]                       modes[10] = '{8'ha5, 8'h5a, 8'hf0, 8'hff, 8'h0f,
		8'h00, 8'ha5, 8'haa, 8'h5a, 8'h55};

	// Array contents: a cheap hash of the address
	function automatic logic [7:0] arr(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
	endfunction
	assign mem_data = arr(mem_addr);

	multi_io_fast_read_engine #(
		.DUAL_IO_DUMMY (fast_read_pkg::DUAL_IO_DUMMY_DEF)
	) dut (
		.clk               (clk),
		.sys_rst           (sys_rst),
		.write_busy        (write_busy),
		.quad_command_mode (quad_command_mode),
		.cont_active       (cont_active),
		.reject_pulse      (reject_pulse),
		.sck               (sck),
		.cs_n              (cs_n),
		.io_i              (io_i),
		.io_o              (io_o),
		.io_oe             (io_oe),
		.mem_addr          (mem_addr),
		.mem_data          (mem_data)
	);

	flash_host_model host (
		.sck   (sck),
		.cs_n  (cs_n),
		.io_i  (io_i),
		.io_o  (io_o),
		.io_oe (io_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------
	// Checking
	// ----------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Count rejections as they cross into the system clock
	always @(posedge clk)
		if (reject_pulse === 1'b1)
			n_rej++;

	// Collect driven groups into bytes; an unexpected byte is a failure
	always @(posedge sck or posedge cs_n)
		if (cs_n)
			nbit = 0;
		else if (io_oe !== 4'h0)
		begin
			if (io_oe[3])
			begin
				sh = {sh[3:0], io_o};
				nbit += 4;
			end
			else
			begin
				sh = {sh[5:0], io_o[1:0]};
				nbit += 2;
			end
			if (nbit == 8)
			begin
				nbit = 0;
				if (expq.size() == 0)
					chk({io_oe, sh}, 12'h0, "unexpected byte");
				else
					chk({io_oe, sh}, expq.pop_front(), "read byte");
			end
		end

	// One read frame; a spare group then deselect tests the mid-byte stop
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] md,
		input int nb, input logic ok);
		int         aw;
		int         dn;
		logic [3:0] oe;
		aw = (op == fast_read_pkg::OP_DUAL_OUT) ? 1 : (op == fast_read_pkg::OP_DUAL_IO) ? 2 : 4;
		oe = (aw == 4) ? fast_read_pkg::OE_QUAD : fast_read_pkg::OE_DUAL;
		dn = (aw == 1) ? fast_read_pkg::DUAL_OUT_DUMMY : (aw == 2) ?
			fast_read_pkg::DUAL_IO_DUMMY_DEF : fast_read_pkg::QUAD_DUMMY;
		host.start();
		if (!cont)
			host.shift(quad_command_mode ? 4 : 1, 8, {16'h0, op});
		host.shift(aw, 24, a);
		if (aw == 4)
			host.shift(4, 8, {16'h0, md});
		host.dummy(dn, aw);
		for (int i = 0; i < nb; i++)
			if (ok)
				expq.push_back({oe, arr(a + 24'(i))});
		host.clocks(nb * 8 / ((aw == 4) ? 4 : 2) + 1);
		host.stop();
		chk({8'h0, io_oe}, 12'h0, "drive after deselect");
		if (aw == 4 && ok)
			cont = (md[7:4] == ~md[3:0]);
		repeat (12) @(posedge clk);
		chk({11'h0, cont_active}, {11'h0, cont}, "continuous flag");
	endtask

	// Short partial frames let level inputs cross into the link domain
	task automatic warm();
		repeat (2)
		begin
			host.start();
			host.shift(1, 1, 24'h0);
			host.stop();
		end
	endtask

	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		n_rej = 0;
		cont = 1'b0;
		sys_rst = 1'b1;
		write_busy = 1'b0;
		quad_command_mode = 1'b0;
		void'($urandom(78));
		repeat (4) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		repeat (4) @(posedge clk);
		chk({11'h0, cont_active}, 12'h0, "flag after reset");
		warm();
		rd(fast_read_pkg::OP_DUAL_OUT, 24'($urandom), 8'h0, 3, 1'b1);
		rd(fast_read_pkg::OP_DUAL_IO, 24'hfffffe, 8'h0, 3, 1'b1);
		foreach (modes[i])
			rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), modes[i], 2, 1'b1);
		// Forced exit by a framed all-ones byte
		rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), 8'h0f, 1, 1'b1);
		host.start();
		host.shift(1, 8, 24'hff);
		host.stop();
		cont = 1'b0;
		repeat (12) @(posedge clk);
		chk({11'h0, cont_active}, 12'h0, "flag after escape");
		rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), 8'h00, 1, 1'b1);
		// Opcode four bits per clock
		@(negedge clk) quad_command_mode = 1'b1;
		warm();
		rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), 8'h00, 2, 1'b1);
		@(negedge clk) quad_command_mode = 1'b0;
		warm();
		// Reads during a write cycle are refused
		@(negedge clk) write_busy = 1'b1;
		warm();
		rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), 8'ha5, 2, 1'b0);
		rd(fast_read_pkg::OP_DUAL_OUT, 24'($urandom), 8'h0, 2, 1'b0);
		chk(12'(n_rej), 12'h2, "rejected reads");
		@(negedge clk) write_busy = 1'b0;
		warm();
		rd(fast_read_pkg::OP_QUAD_IO, 24'($urandom), 8'h00, 1, 1'b1);
		chk(12'(expq.size()), 12'h0, "bytes never seen");
		stop_test();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#300000;
		n_fail++;
		$display("FAIL at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
`default_nettype wire
